// ---- hdl/fsp_pkg.sv ----
// Operation
// - table read loads one byte into latch
// - pointer bit zero picks word byte
// - table read may step the pointer
// - erase clears 64-byte row, low bits ignored
// - no word erase, no bulk erase here
// - 55h then AAh unlock before start
// - core stalled until programming timer expires
// - each long write lasts about 2 ms
// - programming works on 32-byte blocks only
// - 32 holding bytes loaded through latch
// - table writes touch holding bytes only
// - holding bytes FFh after reset, after write
// - FFh holding byte leaves flash unchanged
// - full row update takes about 6 ms
// - on-chip timer sets write duration
// - hardware clears write-start at finish
// - completion sets done flag, software clears
// - reset mid-write lasting one clock, bad attempt or setting write enable from 0 flags error
// - hardware clears erase select after erase
`default_nettype none
package fsp_pkg;
  localparam int PTR_W   = 22;
  localparam int ADR_W   = 4;
  localparam int HOLD_N  = 32;
  localparam int HOLD_W  = 5;
  localparam int ROW_LSB = 6;
  localparam int BLK_LSB = 5;
  localparam int TMR_W   = 17;

  localparam logic [ADR_W-1:0] A_CTRL   = 4'h0;
  localparam logic [ADR_W-1:0] A_UNLOCK = 4'h1;
  localparam logic [ADR_W-1:0] A_LATCH  = 4'h2;
  localparam logic [ADR_W-1:0] A_PTR_L  = 4'h3;
  localparam logic [ADR_W-1:0] A_PTR_H  = 4'h4;
  localparam logic [ADR_W-1:0] A_PTR_U  = 4'h5;
  localparam logic [ADR_W-1:0] A_TCMD   = 4'h6;
  localparam logic [ADR_W-1:0] A_STAT   = 4'h7;

  localparam logic [7:0] UNLOCK_1 = 8'h55;
  localparam logic [7:0] UNLOCK_2 = 8'hAA;
  localparam logic [7:0] HOLD_RST = 8'hFF;
  localparam logic [7:0] ZERO8    = 8'h00;
  localparam logic [5:0] ROW_PAD  = 6'h00;

  localparam int B_PGM = 7;
  localparam int B_CFG = 6;
  localparam int B_ERS = 4;
  localparam int B_ERR = 3;
  localparam int B_WEN = 2;
  localparam int B_WR  = 1;
  localparam int B_TWR = 0;
  localparam int M_LSB = 1;
  localparam int M_MSB = 2;
  localparam int S_DONE = 0;
  localparam int S_BUSY = 1;

  localparam int CLK_PERIOD_NS  = 20;
  localparam int LONG_WRITE_NS  = 2_000_000;
  localparam int LONG_WRITE_CYC = LONG_WRITE_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {PM_KEEP, PM_POSTINC, PM_POSTDEC, PM_PREINC} fsp_pmode_t;
  typedef enum logic [1:0] {S_IDLE, S_RD, S_PGM, S_TMR} fsp_state_t;

  typedef struct packed {
    logic pgm_sel;
    logic cfg_sel;
    logic row_erase;
    logic wr_err;
    logic wr_en;
    logic wr_start;
  } fsp_ctrl_t;

  typedef struct packed {
    logic [PTR_W-1:0] addr;
    logic             erase;
    logic             prog;
    logic [7:0]       wbyte;
  } fsp_flash_t;
endpackage : fsp_pkg
`default_nettype wire

// ---- hdl/fsp_flash_self_prog.sv ----
`default_nettype none
module fsp_flash_self_prog
  import fsp_pkg::*;
#(
  parameter int LONG_CYC = LONG_WRITE_CYC
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_rst_n,
  input  wire logic [ADR_W-1:0] i_addr,
  input  wire logic [7:0]       i_wdata,
  input  wire logic             i_wr,
  input  wire logic             i_rd,
  input  wire logic [15:0]      i_fl_rdata,
  output logic      [7:0]       o_rdata,
  output fsp_flash_t            o_flash,
  output logic                  o_cpu_stall,
  output logic                  o_done_flag
);

  fsp_state_t       state_r;
  fsp_ctrl_t        ctrl_r;
  fsp_flash_t       flash_r;
  logic [PTR_W-1:0] ptr_r;
  logic [7:0]       latch_r;
  logic [7:0]       hold_r [HOLD_N];
  logic [7:0]       rdata_r;
  logic [TMR_W-1:0] tmr_r;
  logic [HOLD_W-1:0] idx_r;
  logic             busy_r;
  logic             done_r;
  logic             ul1_r;
  logic             armed_r;
  logic [7:0]       rd_mux;
  logic             ctrl_wr;
  logic             wr_try;
  logic             wr_ok;
  logic             start;
  logic             cmd_go;
  logic             tread;
  logic             twrite;
  logic             fin;
  fsp_pmode_t       pmode;
  logic [PTR_W-1:0] eff_addr;

  // next pointer value; only the low 21 bits move
  function automatic logic [PTR_W-1:0] fsp_step(
    input logic [PTR_W-1:0] ptr,
    input fsp_pmode_t       mode
  );
    logic [PTR_W-2:0] low;
    low = ptr[PTR_W-2:0];
    unique case (mode)
      PM_POSTINC, PM_PREINC: low = low + 1'b1;
      PM_POSTDEC:            low = low - 1'b1;
      PM_KEEP:               low = ptr[PTR_W-2:0];
    endcase
    return {ptr[PTR_W-1], low};
  endfunction : fsp_step

  // pick high or low half of a flash word
  function automatic logic [7:0] fsp_pick(
    input logic [15:0] word,
    input logic        hi
  );
    return hi ? word[15:8] : word[7:0];
  endfunction : fsp_pick

  assign ctrl_wr  = i_wr && (i_addr == A_CTRL) && !busy_r;
  assign wr_try   = ctrl_wr && i_wdata[B_WR];
  assign wr_ok    = armed_r && i_wdata[B_WEN] && i_wdata[B_PGM] && !i_wdata[B_CFG];
  assign start    = wr_try && wr_ok && (state_r == S_IDLE);
  assign cmd_go   = i_wr && (i_addr == A_TCMD) && (state_r == S_IDLE) && !busy_r;
  assign tread    = cmd_go && !i_wdata[B_TWR];
  assign twrite   = cmd_go && i_wdata[B_TWR];
  assign pmode    = fsp_pmode_t'(i_wdata[M_MSB:M_LSB]);
  assign eff_addr = (pmode == PM_PREINC) ? fsp_step(ptr_r, pmode) : ptr_r;
  assign fin      = (state_r == S_TMR) && (tmr_r == '0);

  assign o_rdata     = rdata_r;
  assign o_flash     = flash_r;
  assign o_cpu_stall = busy_r;
  assign o_done_flag = done_r;

  // register read mux
  always_comb begin
    unique case (i_addr)
      A_CTRL:  rd_mux = {ctrl_r.pgm_sel, ctrl_r.cfg_sel, 1'b0, ctrl_r.row_erase,
                         ctrl_r.wr_err, ctrl_r.wr_en, ctrl_r.wr_start, 1'b0};
      A_LATCH: rd_mux = latch_r;
      A_PTR_L: rd_mux = ptr_r[7:0];
      A_PTR_H: rd_mux = ptr_r[15:8];
      A_PTR_U: rd_mux = {2'b00, ptr_r[PTR_W-1:16]};
      A_STAT:  rd_mux = {6'h00, busy_r, done_r};
      default: rd_mux = ZERO8;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      rdata_r <= ZERO8;
    end else if (i_rd) begin
      rdata_r <= rd_mux;
    end else begin
      rdata_r <= ZERO8;
    end
  end

  // two-write unlock; any start attempt consumes it
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      ul1_r   <= 1'b0;
      armed_r <= 1'b0;
    end else if (i_wr && (i_addr == A_UNLOCK)) begin
      ul1_r   <= (i_wdata == UNLOCK_1);
      armed_r <= ul1_r && (i_wdata == UNLOCK_2);
    end else if (wr_try) begin
      ul1_r   <= 1'b0;
      armed_r <= 1'b0;
    end
  end

  // control bits
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      ctrl_r        <= '0;
      // only the first reset edge still sees a running write
      ctrl_r.wr_err <= busy_r;
    end else if (fin) begin
      ctrl_r.wr_start <= 1'b0;
      ctrl_r.wr_err   <= 1'b0;
      ctrl_r.row_erase <= 1'b0;
    end else if (ctrl_wr) begin
      ctrl_r.pgm_sel   <= i_wdata[B_PGM];
      ctrl_r.cfg_sel   <= i_wdata[B_CFG];
      ctrl_r.row_erase <= i_wdata[B_ERS];
      ctrl_r.wr_en     <= i_wdata[B_WEN];
      if (wr_try && !start) begin
        ctrl_r.wr_err <= 1'b1;
      end else if (i_wdata[B_WEN] && !ctrl_r.wr_en) begin
        ctrl_r.wr_err <= 1'b1;
      end else begin
        ctrl_r.wr_err <= i_wdata[B_ERR];
      end
      if (start) begin
        ctrl_r.wr_start <= 1'b1;
      end
    end
  end

  // completion flag; a new completion beats a clear
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      done_r <= 1'b0;
    end else if (fin) begin
      done_r <= 1'b1;
    end else if (i_wr && (i_addr == A_STAT) && i_wdata[S_DONE]) begin
      done_r <= 1'b0;
    end
  end

  // table pointer
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      ptr_r <= '0;
    end else if (cmd_go) begin
      ptr_r <= fsp_step(ptr_r, pmode);
    end else if (i_wr && !busy_r) begin
      unique case (i_addr)
        A_PTR_L: ptr_r[7:0]          <= i_wdata;
        A_PTR_H: ptr_r[15:8]         <= i_wdata;
        A_PTR_U: ptr_r[PTR_W-1:16]   <= i_wdata[PTR_W-17:0];
        default: ptr_r               <= ptr_r;
      endcase
    end
  end

  // table latch
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      latch_r <= ZERO8;
    end else if (state_r == S_RD) begin
      latch_r <= fsp_pick(i_fl_rdata, flash_r.addr[0]);
    end else if (i_wr && (i_addr == A_LATCH) && !busy_r) begin
      latch_r <= i_wdata;
    end
  end

  // holding bytes
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || fin) begin
      for (int i = 0; i < HOLD_N; i++) begin
        hold_r[i] <= HOLD_RST;
      end
    end else if (twrite) begin
      hold_r[eff_addr[HOLD_W-1:0]] <= latch_r;
    end
  end

  // sequencer and self timer
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      state_r <= S_IDLE;
      flash_r <= '0;
      tmr_r   <= '0;
      idx_r   <= '0;
      busy_r  <= 1'b0;
    end else begin
      flash_r.erase <= 1'b0;
      flash_r.prog  <= 1'b0;
      unique case (state_r)
        S_IDLE: begin
          if (start) begin
            busy_r <= 1'b1;
            tmr_r  <= TMR_W'(LONG_CYC - 1);
            idx_r  <= '0;
            if (i_wdata[B_ERS]) begin
              flash_r.addr  <= {ptr_r[PTR_W-1:ROW_LSB], ROW_PAD};
              flash_r.erase <= 1'b1;
              state_r       <= S_TMR;
            end else begin
              state_r <= S_PGM;
            end
          end else if (tread) begin
            flash_r.addr <= eff_addr;
            state_r      <= S_RD;
          end
        end
        S_RD: begin
          state_r <= S_IDLE;
        end
        S_PGM: begin
          tmr_r         <= tmr_r - 1'b1;
          flash_r.addr  <= {ptr_r[PTR_W-1:BLK_LSB], idx_r};
          flash_r.wbyte <= hold_r[idx_r];
          flash_r.prog  <= (hold_r[idx_r] != HOLD_RST);
          idx_r         <= idx_r + 1'b1;
          if (idx_r == HOLD_W'(HOLD_N - 1)) begin
            state_r <= S_TMR;
          end
        end
        S_TMR: begin
          if (tmr_r == '0) begin
            busy_r  <= 1'b0;
            state_r <= S_IDLE;
          end else begin
            tmr_r <= tmr_r - 1'b1;
          end
        end
      endcase
    end
  end

  latch_byte_a:
  assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    state_r == S_RD |=> latch_r == fsp_pick($past(i_fl_rdata), $past(flash_r.addr[0])))
    else $error("table latch missed the addressed byte");

  ptr_step_a:
  assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    cmd_go && pmode == PM_POSTINC
    |=> ptr_r[PTR_W-2:0] == $past(ptr_r[PTR_W-2:0]) + 1'b1)
    else $error("pointer did not step after table access");

  erase_row_a:
  assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    flash_r.erase |-> flash_r.addr[ROW_LSB-1:0] == ROW_PAD && busy_r)
    else $error("erase not aligned to a row");

  unlock_gate_a:
  assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    wr_try && !armed_r |=> !busy_r ##1 !busy_r)
    else $error("long write started without unlock");

  stall_load_a:
  assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    $rose(busy_r) |-> tmr_r == LONG_CYC - 1)
    else $error("programming timer loaded with wrong length");

  stall_hold_a:
  assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    busy_r && tmr_r != '0 |=> busy_r)
    else $error("stall ended before timer expiry");

  skip_ff_a:
  assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    flash_r.prog |-> flash_r.wbyte != HOLD_RST)
    else $error("erased-value byte was programmed");

  hold_write_a:
  assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    twrite |=> hold_r[$past(eff_addr[HOLD_W-1:0])] == $past(latch_r) && !busy_r)
    else $error("table write did not load holding byte");

  hold_reset_a:
  assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    $fell(busy_r) |-> hold_r[0] == HOLD_RST && hold_r[HOLD_N-1] == HOLD_RST)
    else $error("holding bytes not restored after write");

  wr_clear_a:
  assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    fin |=> !ctrl_r.wr_start && !ctrl_r.row_erase && done_r)
    else $error("finish left start or erase select set");

  err_flag_a:
  assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    wr_try && !wr_ok |=> ctrl_r.wr_err)
    else $error("improper start not flagged");

  ptr_dec_a:
  assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    cmd_go && pmode == PM_POSTDEC
    |=> ptr_r[PTR_W-2:0] == $past(ptr_r[PTR_W-2:0]) - 1'b1)
    else $error("pointer did not step down after table access");

  pre_step_a:
  assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    tread && pmode == PM_PREINC
    |=> flash_r.addr[PTR_W-2:0] == $past(ptr_r[PTR_W-2:0]) + 1'b1)
    else $error("pre-step read used the old pointer");

  prog_block_a:
  assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    flash_r.prog |-> flash_r.addr[PTR_W-1:BLK_LSB] == ptr_r[PTR_W-1:BLK_LSB] && busy_r)
    else $error("programming left the pointed block");

  one_op_a:
  assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    flash_r.prog || flash_r.erase |-> busy_r && !(flash_r.prog && flash_r.erase))
    else $error("array touched outside a long write");

  abort_flag_a:
  assert property (@(posedge i_core_clk)
    !i_rst_n && busy_r |=> ctrl_r.wr_err)
    else $error("reset during a long write not flagged");

  done_keep_a:
  assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    done_r && !(i_wr && i_addr == A_STAT && i_wdata[S_DONE]) |=> done_r)
    else $error("completion flag dropped without a clear");

  start_set_a:
  assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    start |=> busy_r && ctrl_r.wr_start)
    else $error("accepted start did not stall the core");

endmodule : fsp_flash_self_prog
`default_nettype wire

// ---- testbench/fsp_flash_model.sv ----
`default_nettype none
module fsp_flash_model
  import fsp_pkg::*;
(
  input  wire logic       i_core_clk,
  input  wire fsp_flash_t i_flash,
  output logic [15:0]     o_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [128];

  initial for (int i = 0; i < 128; i++) mem[i] = 8'(i) ^ 8'h5A;

  // word wide array, both bytes of the addressed word
  assign o_rdata = {mem[{i_flash.addr[6:1], 1'b1}], mem[{i_flash.addr[6:1], 1'b0}]};

  always @(posedge i_core_clk) begin
    if (i_flash.erase) for (int i = 0; i < 64; i++) mem[{i_flash.addr[6], 6'(i)}] = 8'hFF;
    // programming only clears bits
    if (i_flash.prog) mem[i_flash.addr[6:0]] = mem[i_flash.addr[6:0]] & i_flash.wbyte;
  end
endmodule : fsp_flash_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
`default_nettype none
module tb_top
  import fsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LC = 40;
  logic             clk, rst_n, wr_s, rd_s, stall, done, rd_d;
  logic [ADR_W-1:0] adr;
  logic [7:0]       wd, rdat;
  logic [15:0]      fl_rd;
  fsp_flash_t       fl;
  int               err_total, comparisons, stall_len;
  logic [7:0]       exp_q[$];
  string            nm_q[$];
  logic [7:0]       gold [128];
  logic [7:0]       rv [3];
  fsp_pmode_t       md [5] = '{PM_POSTINC, PM_POSTINC, PM_PREINC, PM_POSTDEC, PM_KEEP};
  int               ra [5] = '{17, 18, 20, 20, 19};

  fsp_flash_self_prog #(.LONG_CYC(LC)) uut (.i_core_clk(clk), .i_rst_n(rst_n), .i_addr(adr),
    .i_wdata(wd), .i_wr(wr_s), .i_rd(rd_s), .i_fl_rdata(fl_rd), .o_rdata(rdat),
    .o_flash(fl), .o_cpu_stall(stall), .o_done_flag(done));
  fsp_flash_model flash (.i_core_clk(clk), .i_flash(fl), .o_rdata(fl_rd));

  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic close_out();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  task automatic wr(logic [ADR_W-1:0] a, logic [7:0] d);
    @(posedge clk);
    wr_s <= 1'b1;
    adr  <= a;
    wd   <= d;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr

  task automatic rd(logic [ADR_W-1:0] a, logic [7:0] e, string n);
    @(posedge clk);
    rd_s <= 1'b1;
    adr  <= a;
    exp_q.push_back(e);
    nm_q.push_back(n);
    @(posedge clk);
    rd_s <= 1'b0;
  endtask : rd

  task automatic long_wr(logic [7:0] c);
    int n = 0;
    wr(A_UNLOCK, UNLOCK_1);
    wr(A_UNLOCK, UNLOCK_2);
    wr(A_CTRL, c);
    @(posedge clk);
    chk("busy", 8'h01, {7'h00, stall});
    while (stall === 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    if (n >= 200) begin
      err_total++;
      close_out();
    end
  endtask : long_wr

  task automatic mem_chk();
    for (int i = 0; i < 128; i++) chk("flash", gold[i], flash.mem[i]);
  endtask : mem_chk

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    if (rd_d && exp_q.size() > 0) chk(nm_q.pop_front(), exp_q.pop_front(), rdat);
    rd_d <= rd_s;
    if (!rst_n) stall_len <= 0;
    else if (stall === 1'b1) stall_len <= stall_len + 1;
    else if (stall_len != 0) begin
      chk("stall", 8'(LC), 8'(stall_len));
      stall_len <= 0;
    end
  end

  initial begin
    {rst_n, wr_s, rd_s, adr, wd} = '0;
    {err_total, comparisons} = '0;
    void'($urandom(29));
    for (int i = 0; i < 128; i++) gold[i] = 8'(i) ^ 8'h5A;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(A_CTRL, 8'h00, "ctrl_rst");
    wr(A_PTR_L, 8'h11);
    for (int i = 0; i < 5; i++) begin
      wr(A_TCMD, {5'h00, md[i], 1'b0});
      rd(A_LATCH, gold[ra[i]], "latch");
    end
    rd(A_PTR_L, 8'h13, "ptr");
    wr(A_PTR_L, 8'h00);
    wr(A_CTRL, 8'h84);
    rd(A_CTRL, 8'h8C, "ctrl_wen");
    for (int k = 0; k < 3; k++) begin
      rv[k] = 8'($urandom);
      wr(A_LATCH, rv[k]);
      wr(A_TCMD, 8'h03);
    end
    mem_chk();
    for (int k = 0; k < 3; k++) gold[k] = gold[k] & rv[k];
    long_wr(8'h86);
    rd(A_CTRL, 8'h84, "ctrl_done");
    rd(A_STAT, 8'h01, "stat");
    chk("done", 8'h01, {7'h00, done});
    wr(A_STAT, 8'h01);
    rd(A_STAT, 8'h00, "stat_clr");
    chk("done_clr", 8'h00, {7'h00, done});
    mem_chk();
    long_wr(8'h86);
    mem_chk();
    wr(A_PTR_L, 8'h47);
    long_wr(8'h96);
    rd(A_CTRL, 8'h84, "ctrl_ers");
    for (int i = 64; i < 128; i++) gold[i] = 8'hFF;
    mem_chk();
    wr(A_CTRL, 8'h86);
    rd(A_CTRL, 8'h8C, "ctrl_bad");
    chk("idle", 8'h00, {7'h00, stall});
    wr(A_UNLOCK, UNLOCK_1);
    wr(A_UNLOCK, UNLOCK_2);
    wr(A_CTRL, 8'h86);
    repeat (5) @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    rd(A_CTRL, 8'h08, "ctrl_abort");
    repeat (2) @(posedge clk);
    close_out();
  end
endmodule : tb_top
`default_nettype wire
